// ===== hdl/rre_defines.vh
/*
  Constants for the return and rotate execution block: opcode patterns,
  field positions, cycle counts and reset values.
  Assumes 14-bit instruction words and an 8-bit data path.
*/
`ifndef RRE_DEFINES_VH
`define RRE_DEFINES_VH

`define RRE_INSN_W 14
`define RRE_DATA_W 8
`define RRE_PC_W 13
`define RRE_FADDR_W 7
`define RRE_LIT_MSB 7
`define RRE_LIT_LSB 0
`define RRE_FADDR_MSB 6
`define RRE_FADDR_LSB 0
`define RRE_DEST_BIT 7
`define RRE_RETLIT_TOP 4'hd
`define RRE_RETLIT_TOP_MSB 13
`define RRE_RETLIT_TOP_LSB 10
`define RRE_RETURN_CODE 14'h0008
`define RRE_ROTATE_TOP 6'h0c
`define RRE_ROTATE_TOP_MSB 13
`define RRE_ROTATE_TOP_LSB 8
`define RRE_BRANCH_CYCLES 2
`define RRE_SIMPLE_CYCLES 1
`define RRE_ACC_RESET 8'h00
`define RRE_CARRY_RESET 1'b0
`define RRE_WDATA_RESET 8'h00
`define RRE_PC_RESET 13'h0000

`endif

// ===== hdl/rre_decode.v
/*
  Opcode decoder for the return and rotate execution block.
  Assumes a registered instruction word in the core clock domain.
*/
`include "rre_defines.vh"

module rre_decode (
  input wire [13:0] insn,
  output wire is_retlit,
  output wire is_return,
  output wire is_rotate,
  output wire [7:0] literal,
  output wire [6:0] faddr,
  output wire dest_file
);
  assign is_retlit = insn[`RRE_RETLIT_TOP_MSB:`RRE_RETLIT_TOP_LSB] == `RRE_RETLIT_TOP;
  assign is_return = insn == `RRE_RETURN_CODE;
  assign is_rotate = insn[`RRE_ROTATE_TOP_MSB:`RRE_ROTATE_TOP_LSB] == `RRE_ROTATE_TOP;
  assign literal = insn[`RRE_LIT_MSB:`RRE_LIT_LSB];
  assign faddr = insn[`RRE_FADDR_MSB:`RRE_FADDR_LSB];
  assign dest_file = insn[`RRE_DEST_BIT];
endmodule // rre_decode

// ===== hdl/rre_exec.v
/*
  Execution unit for return-with-literal, subroutine return and
  rotate-right-via-carry. Holds the working accumulator and carry flag.
  Assumes the core presents one instruction per cycle with insn_valid,
  returns file data combinationally on file_rdata for file_addr, and
  supplies top_stack_entry from the hardware return stack.
  The file write strobe trails the rotate by one cycle, so the core keeps
  the rotate's file address with it. BRANCH_CYCLES is at least 2.
*/
`include "rre_defines.vh"

module rre_exec #(
  parameter PC_W = `RRE_PC_W,
  parameter BRANCH_CYCLES = `RRE_BRANCH_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire insn_valid,
  input wire [13:0] insn,
  input wire [PC_W-1:0] top_stack_entry,
  input wire [7:0] file_rdata,
  output wire [6:0] file_addr,
  output reg file_we,
  output reg [7:0] file_wdata,
  output reg stack_pop,
  output reg pc_load,
  output reg [PC_W-1:0] pc_value,
  output reg flush_fetch,
  output wire busy,
  output reg [7:0] acc,
  output reg carry
);

  localparam ST_RUN = 1'b0;
  localparam ST_FLUSH = 1'b1;
  localparam OP_NONE = 2'b00;
  localparam OP_RETLIT = 2'b01;
  localparam OP_RETURN = 2'b10;
  localparam OP_ROTATE = 2'b11;
  // Hold counter width; covers branch spans up to 16 cycles
  localparam CNT_W = 4;

  reg state;
  reg next_state;
  reg [CNT_W-1:0] hold_cnt;
  reg [CNT_W-1:0] next_hold;
  reg [7:0] next_acc;
  reg next_carry;
  reg next_file_we;
  reg [7:0] next_file_wdata;
  reg next_stack_pop;
  reg next_pc_load;
  reg [PC_W-1:0] next_pc_value;
  reg next_flush;

  wire is_retlit;
  wire is_return;
  wire is_rotate;
  wire [7:0] literal;
  wire dest_file;
  wire [7:0] rot_result;
  wire take;
  wire [1:0] cur_op;
  wire branch_take;
  wire rotate_take;
  wire [31:0] cycles_full;
  wire [CNT_W-1:0] hold_load;

  // One class per accepted word; nothing is accepted outside a run slot
  function [1:0] op_class;
    input slot_ok;
    input retlit_hit;
    input return_hit;
    input rotate_hit;
    begin
      if (!slot_ok) begin
        op_class = OP_NONE;
      end else if (retlit_hit) begin
        op_class = OP_RETLIT;
      end else if (return_hit) begin
        op_class = OP_RETURN;
      end else if (rotate_hit) begin
        op_class = OP_ROTATE;
      end else begin
        op_class = OP_NONE;
      end
    end
  endfunction

  // Classes that reload the program counter from the stack
  function is_branch;
    input [1:0] op;
    begin
      is_branch = (op == OP_RETLIT) || (op == OP_RETURN);
    end
  endfunction

  // Instruction cycles an accepted word occupies
  function [31:0] op_cycles;
    input branch_hit;
    begin
      if (branch_hit) begin
        op_cycles = BRANCH_CYCLES;
      end else begin
        op_cycles = `RRE_SIMPLE_CYCLES;
      end
    end
  endfunction

  rre_decode u_dec (
    .insn(insn),
    .is_retlit(is_retlit),
    .is_return(is_return),
    .is_rotate(is_rotate),
    .literal(literal),
    .faddr(file_addr),
    .dest_file(dest_file)
  );

  // Later cycles of a branch ignore the fetched word
  assign take = insn_valid && (state == ST_RUN);
  assign busy = (state == ST_FLUSH);
  assign cur_op = op_class(take, is_retlit, is_return, is_rotate);
  assign branch_take = is_branch(cur_op);
  assign rotate_take = (cur_op == OP_ROTATE);
  assign cycles_full = op_cycles(is_branch(cur_op));
  assign hold_load = cycles_full[CNT_W-1:0] - 4'h1;

  // Old carry enters the top bit, every other bit moves down one place
  assign rot_result[7] = carry;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_rot
      assign rot_result[gi] = file_rdata[gi + 1];
    end
  endgenerate

  // Next values; strobes default low every cycle
  always @* begin
    next_state = state;
    next_hold = hold_cnt;
    next_acc = acc;
    next_carry = carry;
    next_file_we = 1'b0;
    next_file_wdata = file_wdata;
    next_stack_pop = 1'b0;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_flush = 1'b0;
    case (state)
      ST_RUN: begin
        if (branch_take) begin
          if (cur_op == OP_RETLIT) begin
            next_acc = literal;
          end
          next_pc_value = top_stack_entry;
          next_pc_load = 1'b1;
          next_stack_pop = 1'b1;
          next_flush = 1'b1;
          next_hold = hold_load;
          next_state = ST_FLUSH;
        end else if (rotate_take) begin
          next_carry = file_rdata[0];
          if (dest_file) begin
            next_file_we = 1'b1;
            next_file_wdata = rot_result;
          end else begin
            next_acc = rot_result;
          end
        end
      end
      ST_FLUSH: begin
        // Count down the discarded fetch slots
        if (hold_cnt > 4'h1) begin
          next_hold = hold_cnt - 4'h1;
        end else begin
          next_hold = 4'h0;
          next_state = ST_RUN;
        end
      end
      default: begin
        next_hold = 4'h0;
        next_state = ST_RUN;
      end
    endcase
  end

  // Control registers: sequencing state and the one-cycle strobes
  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_RUN;
      hold_cnt <= 4'h0;
      file_we <= 1'b0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      flush_fetch <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold;
      file_we <= next_file_we;
      stack_pop <= next_stack_pop;
      pc_load <= next_pc_load;
      flush_fetch <= next_flush;
    end
  end

  // Data registers: accumulator, carry and the values handed to the core
  always @(posedge clk) begin
    if (!rst_n) begin
      acc <= `RRE_ACC_RESET;
      carry <= `RRE_CARRY_RESET;
      file_wdata <= `RRE_WDATA_RESET;
      pc_value <= `RRE_PC_RESET;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      file_wdata <= next_file_wdata;
      pc_value <= next_pc_value;
    end
  end
endmodule // rre_exec

// ===== sim/rre_exec_properties.sv
/* Checker for rre_exec. Assumes it is bound to each rre_exec instance. */
module rre_chk (
  input wire clk,
  input wire rst_n,
  input wire insn_valid,
  input wire [13:0] insn,
  input wire [12:0] top_stack_entry,
  input wire [7:0] file_rdata,
  input wire file_we,
  input wire [7:0] file_wdata,
  input wire stack_pop,
  input wire pc_load,
  input wire [12:0] pc_value,
  input wire flush_fetch,
  input wire busy,
  input wire [7:0] acc,
  input wire carry
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = insn_valid && !busy;
  wire lit = insn[13:10] == 4'hd;
  wire ret = insn == 14'h0008;
  wire rot = insn[13:8] == 6'h0c;
  property p_r1; tk && lit |=> acc == $past(insn[7:0]); endproperty
  a_r1: assert property (p_r1) else $error("bad acc");
  property p_r2; tk && lit |=> pc_load && pc_value == $past(top_stack_entry) && $stable(carry); endproperty
  a_r2: assert property (p_r2) else $error("bad pc");
  property p_r3; tk && ret |=> stack_pop && $stable(acc) && pc_value == $past(top_stack_entry); endproperty
  a_r3: assert property (p_r3) else $error("bad pop");
  property p_r4; tk && ret |=> busy && flush_fetch ##1 !busy && !pc_load; endproperty
  a_r4: assert property (p_r4) else $error("bad span");
  property p_r5; tk && rot |=> carry == $past(file_rdata[0]) && !pc_load; endproperty
  a_r5: assert property (p_r5) else $error("bad carry");
  property p_r6;
    tk && rot |=> file_we == $past(insn[7]) &&
      ($past(insn[7]) ? file_wdata : acc) == {$past(carry), $past(file_rdata[7:1])};
  endproperty
  a_r6: assert property (p_r6) else $error("bad dest");
  c_lit: cover property (tk && lit);
  c_ret: cover property (tk && ret);
  c_rot: cover property (tk && rot && insn[7]);
  c_rotw: cover property (tk && rot && !insn[7]);
endmodule // rre_chk
bind rre_exec rre_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .insn_valid(insn_valid),
  .insn(insn),
  .top_stack_entry(top_stack_entry),
  .file_rdata(file_rdata),
  .file_we(file_we),
  .file_wdata(file_wdata),
  .stack_pop(stack_pop),
  .pc_load(pc_load),
  .pc_value(pc_value),
  .flush_fetch(flush_fetch),
  .busy(busy),
  .acc(acc),
  .carry(carry)
);

// ===== sim/tb.sv
/* Random self-checking bench for rre_exec. Assumes file data is free. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [12:0] top_stack_entry = 13'h0000;
  logic [7:0] file_rdata = 8'h00;
  wire file_we;
  wire stack_pop;
  wire pc_load;
  wire flush_fetch;
  wire busy;
  wire carry;
  wire [6:0] file_addr;
  wire [7:0] file_wdata;
  wire [7:0] acc;
  wire [12:0] pc_value;
  integer seed = 32'h8866;
  integer miscompares = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer r;
  integer r2;
  integer k;
  integer m_acc = 0, m_c = 0, m_busy = 0, m_ret = 0, m_we = 0, m_wd = 0, m_fw = 0, m_pc = 0;
  integer q_pc[$];
  always #4 clk = ~clk;
  rre_exec u_rre_exec (
    .clk(clk),
    .rst_n(rst_n),
    .insn_valid(insn_valid),
    .insn(insn),
    .top_stack_entry(top_stack_entry),
    .file_rdata(file_rdata),
    .file_addr(file_addr),
    .file_we(file_we),
    .file_wdata(file_wdata),
    .stack_pop(stack_pop),
    .pc_load(pc_load),
    .pc_value(pc_value),
    .flush_fetch(flush_fetch),
    .busy(busy),
    .acc(acc),
    .carry(carry)
  );
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task cmp_addr(input logic [6:0] got, input logic [6:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t addr got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_pc(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t pc got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 800; k++) begin
      @(negedge clk);
      if (m_ret) m_pc = q_pc.pop_front();
      cmp_byte(acc, m_acc[7:0]);
      cmp_bit(carry, m_c[0]);
      cmp_bit(pc_load, m_ret[0]);
      cmp_bit(stack_pop, m_ret[0]);
      cmp_bit(flush_fetch, m_ret[0]);
      cmp_bit(busy, m_busy[0]);
      cmp_bit(file_we, m_we[0]);
      cmp_addr(file_addr, insn[6:0]);
      cmp_pc(pc_value, m_pc[12:0]);
      cmp_byte(file_wdata, m_fw[7:0]);
      r = $random(seed);
      r2 = $random(seed);
      // Short reset in mid-run, first word offered right after release
      rst_n = (k < 400 || k >= 402);
      case (r[1:0])
        2'd0: insn = {4'hd, r[17:8]};
        2'd1: insn = 14'h0008;
        2'd2: insn = {6'h0c, r[15:8]};
        default: insn = r2[21:8];
      endcase
      top_stack_entry = r[30:18];
      file_rdata = r2[7:0];
      insn_valid = r[31] | r[2];
      m_ret = 0;
      m_we = 0;
      if (!rst_n) begin
        m_acc = 0;
        m_c = 0;
        m_busy = 0;
        m_fw = 0;
        m_pc = 0;
        q_pc.delete();
      end else begin
        if (insn_valid && m_busy == 0) begin
          if (insn[13:10] == 4'hd || insn == 14'h0008) begin
            m_ret = 1;
            q_pc.push_back(top_stack_entry);
            if (insn[13:10] == 4'hd) m_acc = insn[7:0];
          end else if (insn[13:8] == 6'h0c) begin
            m_wd = {m_c[0], file_rdata[7:1]};
            m_c = file_rdata[0];
            if (insn[7]) begin
              m_we = 1;
              m_fw = m_wd;
            end else begin
              m_acc = m_wd;
            end
          end
        end
        m_busy = m_ret;
      end
    end
    complete_run;
  end
endmodule // tb
